// file: verilog/acl_key_params.svh
// constants for the access-list lookup key builder
`ifndef ACL_KEY_PARAMS_SVH
`define ACL_KEY_PARAMS_SVH

// widest key and field widths
`define KEY_MAX_BITS 567
`define EIGHT_SEL_BITS 4
`define SIXTEEN_SEL_BITS 2
`define POLICY_GROUP_BITS 8
`define MASK_MODE_BITS 2
`define MASK_BITS 53
`define PORT_BITS 6
`define PIPE_POINT_BITS 5
`define PIPE_ACTION_BITS 3

// key widths in bits
`define WIDTH_IPV4_VLAN 10'h058
`define WIDTH_MAC_ETHERTYPE 10'h10F
`define WIDTH_ADDR_RESOLUTION 10'h0D2
`define WIDTH_IPV4_TRANSPORT 10'h11B
`define WIDTH_IPV4_MISC 10'h112
`define WIDTH_CUSTOM_B 10'h11C
`define WIDTH_IPV6_VLAN 10'h11C
`define WIDTH_SEVEN_FIELD 10'h237
`define WIDTH_CUSTOM_A 10'h222

// entry words per key class
`define WORDS_QUAD 5'h04
`define WORDS_EIGHT 5'h08
`define WORDS_SIXTEEN 5'h10

// eight-word selector codes
`define SEL8_MAC_ETHERTYPE 4'h0
`define SEL8_ADDR_RESOLUTION 4'h3
`define SEL8_IPV4_TRANSPORT 4'h4
`define SEL8_IPV4_MISC 4'h5
`define SEL8_CUSTOM_B 4'h8
`define SEL8_IPV6_VLAN 4'h9
// sixteen-word selector codes
`define SEL16_SEVEN_FIELD 2'h1
`define SEL16_CUSTOM_A 2'h2

// mode-3 mask layout
`define M3_PROC0_BIT 0
`define M3_PROC1_BIT 1
`define M3_VDEV0_BIT 2
`define M3_VDEV1_BIT 3
`define M3_SRC_LO 4
`define M3_SRC_HI 9
`define M3_PP_LO 44
`define M3_PP_HI 48
`define M3_PA_LO 49
`define M3_PA_HI 51

// pipeline action code meaning masquerade-inject
`define MASQUERADE_INJECT_ACTION 3'h2
// number of front ports with a policy group setting
`define PORT_COUNT 53
`define DEST_MULTICAST_BIT 40

`endif

// file: verilog/acl_key_pkg.sv
// types for the access-list lookup key builder
package acl_key_pkg;
	typedef enum logic [3:0] {
		IPV4_VLAN_KEY = 4'h0,
		MAC_ETHERTYPE_KEY = 4'h1,
		ADDR_RESOLUTION_KEY = 4'h2,
		IPV4_TRANSPORT_KEY = 4'h3,
		IPV4_MISC_KEY = 4'h4,
		CUSTOM_B_KEY = 4'h5,
		IPV6_VLAN_KEY = 4'h6,
		IP_SEVEN_FIELD_KEY = 4'h7,
		CUSTOM_A_KEY = 4'h8
	} keyName_t;

	typedef enum logic [1:0] {
		CLASS_QUAD = 2'h0,
		CLASS_EIGHT = 2'h1,
		CLASS_SIXTEEN = 2'h2
	} keyClass_t;

	typedef enum logic [1:0] {
		MODE_PHYSICAL = 2'h0,
		MODE_LOOPBACK = 2'h1,
		MODE_MASQUERADE = 2'h2,
		MODE_SPECIAL = 2'h3
	} maskMode_t;
endpackage

// file: verilog/policy_group_table.sv
// per-port default policy group storage
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module policy_group_table #(
	parameter int PORTS = `PORT_COUNT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// configuration write
	input wire logic cfgWrite,
	input wire logic [`PORT_BITS-1:0] cfgPort,
	input wire logic [`POLICY_GROUP_BITS-1:0] cfgPolicyGroup,
	// lookup
	input wire logic [`PORT_BITS-1:0] lookupPort,
	output logic [`POLICY_GROUP_BITS-1:0] lookupPolicyGroup
);
	logic [`POLICY_GROUP_BITS-1:0] table_reg [PORTS];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PORTS; i++) begin
				table_reg[i] <= 8'h00;
			end
		end else if (cfgWrite && (int'(cfgPort) < PORTS)) begin
			table_reg[cfgPort] <= cfgPolicyGroup;
		end
	end

	// ports without a setting read as zero
	assign lookupPolicyGroup = (int'(lookupPort) < PORTS) ? table_reg[lookupPort] : 8'h00;
endmodule
`default_nettype wire

// file: verilog/ingress_mask_builder.sv
// ingress mask mode selection and mask formation
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module ingress_mask_builder
	import acl_key_pkg::*;
#(
	parameter logic [`PORT_BITS-1:0] PROC_PORT0 = 6'h35,
	parameter logic [`PORT_BITS-1:0] PROC_PORT1 = 6'h36,
	parameter logic [`PORT_BITS-1:0] VDEV_PORT0 = 6'h37,
	parameter logic [`PORT_BITS-1:0] VDEV_PORT1 = 6'h38
) (
	// frame attributes
	input wire logic [`PORT_BITS-1:0] physSrcPort,
	input wire logic [`PORT_BITS-1:0] injectSrcPort,
	input wire logic injectDstMode,
	input wire logic processorInjected,
	input wire logic loopbackDevice,
	input wire logic [`PORT_BITS-1:0] loopedPort,
	input wire logic [`PIPE_POINT_BITS-1:0] pipelinePoint,
	input wire logic [`PIPE_ACTION_BITS-1:0] pipelineAction,
	// enables
	input wire logic masqueradeMaskEnable,
	input wire logic processorInjectMaskEnable,
	input wire logic virtualDeviceMaskEnable,
	input wire logic loopbackMode3Enable,
	// result
	output maskMode_t ingressMaskMode,
	output logic [`MASK_BITS-1:0] ingressSourceMask
);
	logic masqueraded;
	logic fromVdev;
	logic [`PORT_BITS-1:0] srcPortSeen;

	assign masqueraded = (injectDstMode && (injectSrcPort != physSrcPort))
		|| (pipelineAction == `MASQUERADE_INJECT_ACTION);
	assign fromVdev = (physSrcPort == VDEV_PORT0) || (physSrcPort == VDEV_PORT1);
	assign srcPortSeen = masqueraded ? injectSrcPort : (loopbackDevice ? loopedPort : physSrcPort);

	// highest qualifying mode wins
	always_comb begin
		if ((processorInjected && processorInjectMaskEnable) || (fromVdev && virtualDeviceMaskEnable)
			|| (loopbackDevice && loopbackMode3Enable)) begin
			ingressMaskMode = MODE_SPECIAL;
		end else if (masqueraded && masqueradeMaskEnable) begin
			ingressMaskMode = MODE_MASQUERADE;
		end else if (loopbackDevice) begin
			ingressMaskMode = MODE_LOOPBACK;
		end else begin
			ingressMaskMode = MODE_PHYSICAL;
		end
	end

	always_comb begin
		ingressSourceMask = '0;
		unique case (ingressMaskMode)
			MODE_PHYSICAL: ingressSourceMask = 53'h1 << physSrcPort;
			MODE_LOOPBACK: ingressSourceMask = 53'h1 << loopedPort;
			MODE_MASQUERADE: ingressSourceMask = 53'h1 << injectSrcPort;
			MODE_SPECIAL: begin
				ingressSourceMask[`M3_PROC0_BIT] = (physSrcPort == PROC_PORT0);
				ingressSourceMask[`M3_PROC1_BIT] = (physSrcPort == PROC_PORT1);
				ingressSourceMask[`M3_VDEV0_BIT] = (physSrcPort == VDEV_PORT0);
				ingressSourceMask[`M3_VDEV1_BIT] = (physSrcPort == VDEV_PORT1);
				ingressSourceMask[`M3_SRC_HI:`M3_SRC_LO] = srcPortSeen;
				ingressSourceMask[`M3_PP_HI:`M3_PP_LO] = pipelinePoint;
				ingressSourceMask[`M3_PA_HI:`M3_PA_LO] = pipelineAction;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: verilog/acl_lookup_key_builder.sv
// access-list lookup key builder top
// Operation
// - each key spans four, eight or sixteen entry words, setting its class
// - key width is fixed per key type, 88 to 567 bits
// - fields packed back to back from entry bit 0 in fixed order
// - eight-word keys: selector at bits 3:0, first-lookup flag at bit 4
// - selector codes for eight-word and sixteen-word key types
// - first-lookup flag set on first lookup, cleared on second
// - every key carries policy group, defaulting from per-port setting
// - mask mode 0 by default, 1 for frames from loopback device
// - mode 0 mask bit marks physical ingress port
// - mode 2 for masqueraded frames when masquerade enable set; bit marks that port
// - masqueraded: injected with differing source port, or masquerade-inject action
// - mode 3 for processor-injected, virtual device or loopback frames with enables
// - highest qualifying mask mode wins
// - mode 3 bits 0-3 flag processor ports and virtual devices as source
// - mode 3 bits 4-9 carry source port number
// - mode 3 bits 44-48 pipeline point, 49-51 pipeline action, 52 reserved
// - multicast flag set when destination address bit 40 is one
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module acl_lookup_key_builder
	import acl_key_pkg::*;
#(
	parameter int PORTS = `PORT_COUNT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// per-port policy group setting
	input wire logic cfgWrite,
	input wire logic [`PORT_BITS-1:0] cfgPort,
	input wire logic [`POLICY_GROUP_BITS-1:0] cfgPolicyGroup,
	// mask mode enables
	input wire logic masqueradeMaskEnable,
	input wire logic processorInjectMaskEnable,
	input wire logic virtualDeviceMaskEnable,
	input wire logic loopbackMode3Enable,
	// key request from the frame analyzer
	input wire logic keyRequest,
	input wire logic [3:0] keyName,
	input wire logic firstLookup,
	input wire logic policyGroupValid,
	input wire logic [`POLICY_GROUP_BITS-1:0] classifiedPolicyGroup,
	input wire logic [`PORT_BITS-1:0] physSrcPort,
	input wire logic [`PORT_BITS-1:0] injectSrcPort,
	input wire logic injectDstMode,
	input wire logic processorInjected,
	input wire logic loopbackDevice,
	input wire logic [`PORT_BITS-1:0] loopedPort,
	input wire logic [`PIPE_POINT_BITS-1:0] pipelinePoint,
	input wire logic [`PIPE_ACTION_BITS-1:0] pipelineAction,
	input wire logic [47:0] destMac,
	// built key toward the match array
	output logic keyValid,
	output logic [`KEY_MAX_BITS-1:0] keyData,
	output logic [9:0] keyWidth,
	output logic [4:0] keyWords,
	output logic keyError
);
	keyName_t keySel;
	keyClass_t keyClass;
	maskMode_t ingressMaskMode;
	logic [`MASK_BITS-1:0] ingressSourceMask;
	logic [`POLICY_GROUP_BITS-1:0] portDefaultPolicyGroup;
	logic [`POLICY_GROUP_BITS-1:0] policyGroup;
	logic destMulticastFlag;
	logic [`EIGHT_SEL_BITS-1:0] eightSel;
	logic [`SIXTEEN_SEL_BITS-1:0] sixteenSel;
	logic hasMaskFields;
	logic legalName;
	logic [9:0] widthNext;
	logic [4:0] wordsNext;
	logic [`KEY_MAX_BITS-1:0] packed_;
	logic [`KEY_MAX_BITS-1:0] widthMask;
	logic [`KEY_MAX_BITS-1:0] keyData_next;
	logic keyValid_reg;
	logic [`KEY_MAX_BITS-1:0] keyData_reg;
	logic [9:0] keyWidth_reg;
	logic [4:0] keyWords_reg;
	logic keyError_reg;

	////////////////////////////////////////////////////////////////////////
	// field sources

	policy_group_table #(
		.PORTS(PORTS)
	) pgTable (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.cfgWrite(cfgWrite),
		.cfgPort(cfgPort),
		.cfgPolicyGroup(cfgPolicyGroup),
		.lookupPort(physSrcPort),
		.lookupPolicyGroup(portDefaultPolicyGroup)
	);

	ingress_mask_builder maskBuilder (
		.physSrcPort(physSrcPort),
		.injectSrcPort(injectSrcPort),
		.injectDstMode(injectDstMode),
		.processorInjected(processorInjected),
		.loopbackDevice(loopbackDevice),
		.loopedPort(loopedPort),
		.pipelinePoint(pipelinePoint),
		.pipelineAction(pipelineAction),
		.masqueradeMaskEnable(masqueradeMaskEnable),
		.processorInjectMaskEnable(processorInjectMaskEnable),
		.virtualDeviceMaskEnable(virtualDeviceMaskEnable),
		.loopbackMode3Enable(loopbackMode3Enable),
		.ingressMaskMode(ingressMaskMode),
		.ingressSourceMask(ingressSourceMask)
	);

	// earlier classification overrides the port default
	assign policyGroup = policyGroupValid ? classifiedPolicyGroup : portDefaultPolicyGroup;
	assign destMulticastFlag = destMac[`DEST_MULTICAST_BIT];
	// codes past the last key type land in the decode default
	assign keySel = keyName_t'(keyName);

	////////////////////////////////////////////////////////////////////////
	// key type decode

	always_comb begin
		legalName = 1'b1;
		keyClass = CLASS_EIGHT;
		eightSel = `SEL8_MAC_ETHERTYPE;
		sixteenSel = `SEL16_SEVEN_FIELD;
		hasMaskFields = 1'b1;
		widthNext = `WIDTH_MAC_ETHERTYPE;
		// mask fields ride only on the keys whose layout carries them
		case (keySel)
			IPV4_VLAN_KEY: begin
				keyClass = CLASS_QUAD;
				hasMaskFields = 1'b0;
				widthNext = `WIDTH_IPV4_VLAN;
			end
			MAC_ETHERTYPE_KEY: begin
				eightSel = `SEL8_MAC_ETHERTYPE;
				widthNext = `WIDTH_MAC_ETHERTYPE;
			end
			ADDR_RESOLUTION_KEY: begin
				eightSel = `SEL8_ADDR_RESOLUTION;
				widthNext = `WIDTH_ADDR_RESOLUTION;
			end
			IPV4_TRANSPORT_KEY: begin
				eightSel = `SEL8_IPV4_TRANSPORT;
				widthNext = `WIDTH_IPV4_TRANSPORT;
			end
			IPV4_MISC_KEY: begin
				eightSel = `SEL8_IPV4_MISC;
				widthNext = `WIDTH_IPV4_MISC;
			end
			CUSTOM_B_KEY: begin
				eightSel = `SEL8_CUSTOM_B;
				widthNext = `WIDTH_CUSTOM_B;
			end
			IPV6_VLAN_KEY: begin
				eightSel = `SEL8_IPV6_VLAN;
				hasMaskFields = 1'b0;
				widthNext = `WIDTH_IPV6_VLAN;
			end
			IP_SEVEN_FIELD_KEY: begin
				keyClass = CLASS_SIXTEEN;
				sixteenSel = `SEL16_SEVEN_FIELD;
				widthNext = `WIDTH_SEVEN_FIELD;
			end
			CUSTOM_A_KEY: begin
				keyClass = CLASS_SIXTEEN;
				sixteenSel = `SEL16_CUSTOM_A;
				widthNext = `WIDTH_CUSTOM_A;
			end
			default: begin
				// unknown names give an all-zero key and a flag
				legalName = 1'b0;
				widthNext = 10'h000;
			end
		endcase
	end

	always_comb begin
		unique case (keyClass)
			CLASS_QUAD: wordsNext = `WORDS_QUAD;
			CLASS_SIXTEEN: wordsNext = `WORDS_SIXTEEN;
			default: wordsNext = `WORDS_EIGHT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// packing, lowest field at entry bit 0

	always_comb begin
		packed_ = '0;
		unique case (keyClass)
			CLASS_QUAD: begin
				// no type selector: first-lookup flag sits at bit 0
				packed_ = `KEY_MAX_BITS'({
					policyGroup, // bits 8:1
					firstLookup // bit 0
				});
			end
			CLASS_SIXTEEN: begin
				packed_ = `KEY_MAX_BITS'({
					destMulticastFlag, // bit 66
					ingressSourceMask, // bits 65:13
					ingressMaskMode, // bits 12:11
					policyGroup, // bits 10:3
					firstLookup, // bit 2
					sixteenSel // bits 1:0
				});
			end
			default: begin
				if (hasMaskFields) begin
					packed_ = `KEY_MAX_BITS'({
						destMulticastFlag, // bit 68
						ingressSourceMask, // bits 67:15
						ingressMaskMode, // bits 14:13
						policyGroup, // bits 12:5
						firstLookup, // bit 4
						eightSel // bits 3:0
					});
				end else begin
					// ipv6 vlan key stops after the policy group
					packed_ = `KEY_MAX_BITS'({
						policyGroup, // bits 12:5
						firstLookup, // bit 4
						eightSel // bits 3:0
					});
				end
			end
		endcase
	end

	// bits past the key width stay zero
	always_comb begin
		widthMask = '0;
		for (int i = 0; i < `KEY_MAX_BITS; i++) begin
			widthMask[i] = (i < int'(widthNext));
		end
	end

	// an unknown name yields an all-zero key rather than a partial one
	always_comb begin
		keyData_next = '0;
		if (legalName) begin
			keyData_next = packed_ & widthMask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output registers, one cycle after the request

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			keyValid_reg <= 1'b0;
		end else begin
			keyValid_reg <= keyRequest;
		end
	end

	// key held until the next request
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			keyData_reg <= '0;
		end else if (keyRequest) begin
			keyData_reg <= keyData_next;
		end
	end

	// size fields travel with the key so the array can tell its class
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			keyWidth_reg <= 10'h000;
		end else if (keyRequest) begin
			keyWidth_reg <= widthNext;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			keyWords_reg <= 5'h00;
		end else if (keyRequest) begin
			keyWords_reg <= legalName ? wordsNext : 5'h00;
		end
	end

	// error stands only until the next request replaces it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			keyError_reg <= 1'b0;
		end else if (keyRequest) begin
			keyError_reg <= !legalName;
		end
	end

	assign keyValid = keyValid_reg;
	assign keyData = keyData_reg;
	assign keyWidth = keyWidth_reg;
	assign keyWords = keyWords_reg;
	assign keyError = keyError_reg;
endmodule
`default_nettype wire

// file: tb/acl_match_sink.sv
// match array stand-in: keeps the last key handed over
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module acl_match_sink (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// key from the builder
	input wire logic keyValid,
	input wire logic [`KEY_MAX_BITS-1:0] keyData,
	// captured state
	output logic [`KEY_MAX_BITS-1:0] entryKey,
	output logic [15:0] keyCount
);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			entryKey <= '0;
			keyCount <= 16'h0000;
		end else if (keyValid) begin
			entryKey <= keyData;
			keyCount <= keyCount + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: tb/acl_key_monitor.sv
// port checks for the lookup key builder
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module acl_key_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// request side
	input wire logic keyRequest,
	input wire logic [3:0] keyName,
	input wire logic firstLookup,
	input wire logic policyGroupValid,
	input wire logic [`POLICY_GROUP_BITS-1:0] classifiedPolicyGroup,
	input wire logic loopbackDevice,
	input wire logic loopbackMode3Enable,
	input wire logic [47:0] destMac,
	// key side
	input wire logic keyValid,
	input wire logic [`KEY_MAX_BITS-1:0] keyData,
	input wire logic [9:0] keyWidth,
	input wire logic [4:0] keyWords,
	input wire logic keyError
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence eightReq;
		keyRequest && keyName inside {[4'h1:4'h5]};
	endsequence
	sequence loopM3Req;
		eightReq ##0 (loopbackDevice && loopbackMode3Enable);
	endsequence
	AST_ANSWER: assert property (keyRequest |=> keyValid && $past(keyRequest))
		else $error("no key after request");
	AST_QUIET: assert property (!keyRequest |=> !keyValid)
		else $error("key without request");
	AST_QUAD: assert property (keyRequest && keyName == 4'h0
		|=> keyWidth == 10'h058 && keyWords == 5'h04)
		else $error("quad key size wrong");
	AST_SIXTEEN: assert property (keyRequest && keyName == 4'h7
		|=> keyWidth == 10'h237 && keyWords == 5'h10)
		else $error("sixteen-word key size wrong");
	AST_FIRST: assert property (eightReq
		|=> keyData[4] == $past(firstLookup) && keyWords == 5'h08)
		else $error("first-lookup bit wrong");
	AST_SEL_V6: assert property (keyRequest && keyName == 4'h6 |=> keyData[3:0] == 4'h9)
		else $error("ipv6 selector wrong");
	AST_MCAST: assert property (eightReq |=> keyData[68] == $past(destMac[40]))
		else $error("multicast bit wrong");
	AST_GROUP: assert property (eightReq ##0 policyGroupValid
		|=> keyData[12:5] == $past(classifiedPolicyGroup))
		else $error("policy group wrong");
	AST_LOOP3: assert property (loopM3Req |=> keyData[14:13] == 2'h3)
		else $error("mode 3 not chosen");
	AST_M3ZERO: assert property (keyValid && keyWords == 5'h08 && keyData[3:0] != 4'h9
		&& keyData[14:13] == 2'h3 |-> keyData[58:25] == '0 && !keyData[67])
		else $error("mode 3 unused bits set");
	AST_ILLEGAL: assert property (keyRequest && keyName > 4'h8
		|=> keyError && keyData == '0 && keyWords == 5'h00)
		else $error("illegal name not flagged");
endmodule
`default_nettype wire
bind acl_lookup_key_builder acl_key_monitor mon_u (.clk_sys, .reset_n, .keyRequest, .keyName,
	.firstLookup, .policyGroupValid, .classifiedPolicyGroup, .loopbackDevice, .loopbackMode3Enable,
	.destMac, .keyValid, .keyData, .keyWidth, .keyWords, .keyError);

// file: tb/acl_lookup_key_builder_test.sv
// self-checking bench for the lookup key builder
`timescale 1ns/100ps
`default_nettype none
`include "acl_key_params.svh"
module acl_lookup_key_builder_test;
	logic clk_sys = 1'b0, reset_n = 1'b0, cfgWrite = 1'b0, keyRequest = 1'b0, firstLookup = 1'b0;
	logic masqueradeMaskEnable = 1'b0, processorInjectMaskEnable = 1'b0, injectDstMode = 1'b0;
	logic virtualDeviceMaskEnable = 1'b0, loopbackMode3Enable = 1'b0, policyGroupValid = 1'b0;
	logic processorInjected = 1'b0, loopbackDevice = 1'b0, keyValid, keyError;
	logic [5:0] cfgPort = 6'h00, physSrcPort = 6'h00, injectSrcPort = 6'h00, loopedPort = 6'h00;
	logic [7:0] cfgPolicyGroup = 8'h00, classifiedPolicyGroup = 8'h00;
	logic [3:0] keyName = 4'h0;
	logic [4:0] pipelinePoint = 5'h00, keyWords, expWords = 5'h00;
	logic [2:0] pipelineAction = 3'h0;
	logic [47:0] destMac = 48'h0000_0000_0000;
	logic [566:0] keyData, entryKey, expData = '0;
	logic [9:0] keyWidth, expWidth = 10'h000;
	logic [15:0] keyCount;
	logic [7:0] pgTable [64] = '{default: 8'h00};
	logic expErr = 1'b0, expValid = 1'b0;
	int num_errors = 0, cmp_count = 0, reqCount = 0, seed = 32'h6c68_b980;
	localparam logic [9:0] WIDTHS [9] = '{10'h058, 10'h10F, 10'h0D2, 10'h11B, 10'h112, 10'h11C,
		10'h11C, 10'h237, 10'h222};
	localparam logic [3:0] SEL8 [9] = '{4'h0, 4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'h0, 4'h0};

	acl_lookup_key_builder dut_u (.clk_sys, .reset_n, .cfgWrite, .cfgPort, .cfgPolicyGroup,
		.masqueradeMaskEnable, .processorInjectMaskEnable, .virtualDeviceMaskEnable,
		.loopbackMode3Enable, .keyRequest, .keyName, .firstLookup, .policyGroupValid,
		.classifiedPolicyGroup, .physSrcPort, .injectSrcPort, .injectDstMode, .processorInjected,
		.loopbackDevice, .loopedPort, .pipelinePoint, .pipelineAction, .destMac, .keyValid,
		.keyData, .keyWidth, .keyWords, .keyError);
	acl_match_sink sink_u (.clk_sys, .reset_n, .keyValid, .keyData, .entryKey, .keyCount);

	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd(input int lim);
		rnd = $unsigned($random(seed)) % lim;
	endfunction
	function automatic logic [52:0] oneHot(input logic [5:0] p);
		oneHot = (p < 6'h35) ? (53'h1 << p) : '0;
	endfunction
	function automatic logic [566:0] expKey();
		logic masq, vdev;
		logic [1:0] md;
		logic [52:0] msk;
		logic [7:0] pg;
		logic [5:0] src;
		logic [566:0] k;
		masq = (injectDstMode && injectSrcPort != physSrcPort) || pipelineAction == 3'h2;
		vdev = physSrcPort == 6'h37 || physSrcPort == 6'h38;
		md = ((processorInjected && processorInjectMaskEnable) || (vdev && virtualDeviceMaskEnable)
			|| (loopbackDevice && loopbackMode3Enable)) ? 2'h3 : (masq && masqueradeMaskEnable)
			? 2'h2 : loopbackDevice ? 2'h1 : 2'h0;
		src = masq ? injectSrcPort : loopbackDevice ? loopedPort : physSrcPort;
		case (md)
			2'h0: msk = oneHot(physSrcPort);
			2'h1: msk = oneHot(loopedPort);
			2'h2: msk = oneHot(injectSrcPort);
			default: msk = {1'b0, pipelineAction, pipelinePoint, 34'h0, src, physSrcPort == 6'h38,
				vdev && physSrcPort == 6'h37, physSrcPort == 6'h36, physSrcPort == 6'h35};
		endcase
		pg = policyGroupValid ? classifiedPolicyGroup : pgTable[physSrcPort];
		k = '0;
		case (keyName)
			4'h0: k[8:0] = {pg, firstLookup};
			4'h6: k[12:0] = {pg, firstLookup, 4'h9};
			4'h7, 4'h8: k[66:0] = {destMac[40], msk, md, pg, firstLookup,
				(keyName == 4'h7) ? 2'h1 : 2'h2};
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5: k[68:0] = {destMac[40], msk, md, pg, firstLookup,
				SEL8[keyName]};
			default: k = '0;
		endcase
		return k;
	endfunction

	////////////////////////////////////////////////////////////////
	task automatic miss(input string nm, input logic [566:0] e, input logic [566:0] s);
		num_errors++;
		$display("Error %s expected %h seen %h", nm, e, s);
	endtask
	task automatic chkWide(input string nm, input logic [566:0] e, input logic [566:0] s);
		cmp_count++;
		if (s !== e) miss(nm, e, s);
	endtask
	task automatic chkNum(input string nm, input logic [9:0] e, input logic [9:0] s);
		cmp_count++;
		if (s !== e) miss(nm, 567'(e), 567'(s));
	endtask
	task automatic chkBit(input string nm, input logic e, input logic s);
		cmp_count++;
		if (s !== e) miss(nm, 567'(e), 567'(s));
	endtask
	task automatic checkOut();
		chkBit("keyValid", expValid, keyValid);
		chkWide("keyData", expData, keyData);
		chkNum("keyWidth", expWidth, keyWidth);
		chkNum("keyWords", 10'(expWords), 10'(keyWords));
		chkBit("keyError", expErr, keyError);
	endtask
	task automatic driveNext(input int i);
		keyRequest = i < 32 || rnd(4) != 0;
		keyName = (i < 32) ? 4'(i % 16) : 4'(rnd(9));
		firstLookup = rnd(2) == 1;
		physSrcPort = 6'(rnd(57));
		policyGroupValid = rnd(2) == 1 || physSrcPort > 6'h34;
		classifiedPolicyGroup = 8'(rnd(256));
		injectSrcPort = rnd(2) == 1 ? physSrcPort : 6'(rnd(57));
		loopedPort = 6'(rnd(57));
		pipelinePoint = 5'(rnd(32));
		pipelineAction = 3'(rnd(8));
		destMac = {16'(rnd(65536)), 32'($random(seed))};
		{masqueradeMaskEnable, processorInjectMaskEnable} = 2'(rnd(4));
		{virtualDeviceMaskEnable, loopbackMode3Enable, injectDstMode} = 3'(rnd(8));
		processorInjected = rnd(4) == 0;
		loopbackDevice = rnd(3) == 0;
		cfgWrite = rnd(2) == 1;
		cfgPort = 6'(rnd(64));
		cfgPolicyGroup = 8'(rnd(256));
		expValid = keyRequest;
		if (keyRequest) begin
			expData = expKey();
			expErr = keyName > 4'h8;
			expWidth = expErr ? 10'h000 : WIDTHS[keyName];
			expWords = expErr ? 5'h00 : keyName == 4'h0 ? 5'h04 : keyName > 4'h6 ? 5'h10 : 5'h08;
			reqCount++;
		end
		// same-edge write is seen only by later requests
		if (cfgWrite && cfgPort < 6'h35) pgTable[cfgPort] = cfgPolicyGroup;
	endtask
	// mid-run reset: outputs, sink count and port defaults all return to zero
	task automatic midReset();
		keyRequest = 1'b0;
		cfgWrite = 1'b0;
		reset_n = 1'b0;
		expValid = 1'b0;
		expData = '0;
		expWidth = 10'h000;
		expWords = 5'h00;
		expErr = 1'b0;
		reqCount = 0;
		pgTable = '{default: 8'h00};
		#1;
		checkOut();
		repeat (2) @(posedge clk_sys);
		#1 reset_n = 1'b1;
	endtask
	task automatic final_report();
		if (num_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		for (int i = 0; i < 600; i++) begin
			checkOut();
			if (i == 300) midReset();
			driveNext(i);
			@(posedge clk_sys);
			#1;
		end
		keyRequest = 1'b0;
		cfgWrite = 1'b0;
		checkOut();
		expValid = 1'b0;
		@(posedge clk_sys);
		#1;
		checkOut();
		chkNum("keyCount", 10'(reqCount), keyCount[9:0]);
		chkWide("entryKey", expData, entryKey);
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		final_report();
	end
endmodule
`default_nettype wire
